// ==== verilog/scs_pkg.sv ====
/*
 * Package for the system clock select block: register offsets, field
 * positions, reset values, timing figures and the operating mode type.
 * Assumes a single 50 MHz clock and byte addresses from an AXI4-Lite master.
 */
package scs_pkg;

    // ==========================================================
    // clock and timing
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned SLOW_OSC_HZ     = 32_000;
    localparam int unsigned SLOW_TICK_DIV   = CLK_HZ / SLOW_OSC_HZ;       // period half a cycle short, rounds down
    localparam int unsigned FAST_START_NS   = 20_000;
    localparam int unsigned FAST_START_CYC  = (FAST_START_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [3:0] CLK_SEL_OFFSET   = 4'h0;
    localparam logic [3:0] OSC_CTRL_OFFSET  = 4'h4;

    // ==========================================================
    // field positions
    localparam int unsigned SRC_MSB         = 7;
    localparam int unsigned SRC_LSB         = 5;
    localparam int unsigned KEEP_FAST_BIT   = 1;
    localparam int unsigned KEEP_SLOW_BIT   = 0;
    localparam int unsigned STABLE_BIT      = 1;
    localparam int unsigned ENABLE_BIT      = 0;

    // ==========================================================
    // reset values and encodings
    localparam logic [2:0] SRC_RESET        = 3'h0;
    localparam logic [2:0] SRC_SLOW         = 3'h7;
    localparam logic       KEEP_RESET       = 1'b0;
    localparam logic       ENABLE_RESET     = 1'b1;
    localparam logic [1:0] RESP_OKAY        = 2'h0;
    localparam logic [1:0] RESP_SLVERR      = 2'h2;

    typedef enum logic [2:0] {
        MODE_FAST           = 3'b000,
        MODE_SLOW           = 3'b001,
        MODE_SLEEP          = 3'b010,
        MODE_IDLE_SLOW_ONLY = 3'b011,
        MODE_IDLE_BOTH_OSC  = 3'b100,
        MODE_IDLE_FAST_ONLY = 3'b101
    } scs_mode_type;

endpackage : scs_pkg

// ==== verilog/scs_tick_gen.sv ====
/*
 * One-cycle tick every PERIOD clocks while run is high; stands for a
 * free-running oscillator edge. Assumes run is synchronous to clk.
 */
`timescale 1ns/1ps
module scs_tick_gen #(
    parameter int unsigned PERIOD = 1562
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic run,
    output logic      tick
);
    localparam int unsigned CW = $clog2(PERIOD + 1);

    logic [CW-1:0] count_q;

    // ==========================================================
    // period counter; restarts from zero whenever the oscillator stops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else if (!run) begin
            count_q <= '0;
            tick    <= 1'b0;
        end else if (count_q == CW'(PERIOD - 1)) begin
            count_q <= '0;
            tick    <= 1'b1;
        end else begin
            count_q <= count_q + CW'(1);
            tick    <= 1'b0;
        end
    end

endmodule : scs_tick_gen

// ==== verilog/scs_clock_select.sv ====
/*
 * System clock select and fast oscillator control, reached over AXI4-Lite.
 * The fast oscillator is modelled by clk itself; system clock is delivered
 * as a one-cycle enable. Assumes haltPulse/wakeUp come from the CPU core.
 */
`timescale 1ns/1ps
module scs_clock_select
    import scs_pkg::*;
#(
    parameter int unsigned START_CYC = FAST_START_CYC,
    parameter int unsigned SLOW_DIV  = SLOW_TICK_DIV
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        haltPulse,
    input  wire logic        wakeUp,
    output logic             sysClkEn_q,
    output logic             fastOscOn_q,
    output logic             slowOscOn_q,
    output scs_mode_type     mode_q
);
    localparam int unsigned SW = $clog2(START_CYC + 1);

    logic [2:0]    srcField_q;
    logic          keepFast_q, keepSlow_q, fastEnable_q, stable_q, halted_q;
    logic [SW-1:0] settle_q;
    logic [5:0]    fastCnt_q;
    logic [2:0]    activeSrc_q;
    logic [3:0]    awAddr_q;
    logic [31:0]   wData_q;
    logic [3:0]    wStrb_q;
    logic          awHave_q, wHave_q, fastRunPrev_q;
    logic          fastRun, slowRun, slowTick, curTick, srcDead, canSwitch, doWrite;
    logic [7:0]    selReg, oscReg;

    // ==========================================================
    // oscillator run conditions during normal run and halt
    assign fastRun = fastEnable_q && !(halted_q && !keepFast_q);
    assign slowRun = !(halted_q && !keepSlow_q);
    assign selReg  = {srcField_q, 3'h0, keepFast_q, keepSlow_q};
    assign oscReg  = {6'h00, stable_q, fastEnable_q};

    scs_tick_gen #(.PERIOD(SLOW_DIV)) slowOsc (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (slowRun),
        .tick    (slowTick)
    );

    // ==========================================================
    // divided fast clock: /2^k ticks when the low k bits are all ones
    function automatic logic divTick(input logic [2:0] sel, input logic [5:0] cnt);
        logic [5:0] mask;
        mask = 6'(((7'h01 << sel) - 7'h01));
        return ((cnt | ~mask) == 6'h3F);
    endfunction : divTick

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            fastCnt_q <= 6'h00;
        else if (fastRun)
            fastCnt_q <= fastCnt_q + 6'h01;
    end

    // current source at a period edge, or it no longer oscillates at all
    assign curTick   = (activeSrc_q == SRC_SLOW) ? slowTick
                     : (fastRun && stable_q && divTick(activeSrc_q, fastCnt_q));
    assign srcDead   = (activeSrc_q == SRC_SLOW) ? !slowRun : !(fastRun && stable_q);
    // a fast target must still be running, or the flag drops just after the handover
    assign canSwitch = (curTick || srcDead) && ((srcField_q == SRC_SLOW) || (stable_q && fastRun));

    // ==========================================================
    // glitch-free handover; a held-off switch keeps the old clock running
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            activeSrc_q <= SRC_RESET;
        else if (activeSrc_q != srcField_q && canSwitch)
            activeSrc_q <= srcField_q;
    end

    // system clock enable: nothing while the CPU is halted
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            sysClkEn_q <= 1'b0;
        else
            sysClkEn_q <= !halted_q && curTick;
    end

    // ==========================================================
    // start-up settling: flag drops on every fast oscillator start
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fastRunPrev_q <= 1'b0;
            settle_q      <= '0;
            stable_q      <= 1'b0;
        end else begin
            fastRunPrev_q <= fastRun;
            if (!fastRun || !fastRunPrev_q) begin
                settle_q <= '0;
                stable_q <= 1'b0;
            end else if (settle_q == SW'(START_CYC - 1)) begin
                stable_q <= 1'b1;
            end else begin
                settle_q <= settle_q + SW'(1);
            end
        end
    end

    // ==========================================================
    // halt and low-power mode selection
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            halted_q <= 1'b0;
            mode_q   <= MODE_FAST;
        end else if (!halted_q && haltPulse) begin
            halted_q <= 1'b1;
            unique case ({keepFast_q, keepSlow_q})
                2'b00: mode_q <= MODE_SLEEP;
                2'b01: mode_q <= MODE_IDLE_SLOW_ONLY;
                2'b11: mode_q <= MODE_IDLE_BOTH_OSC;
                2'b10: mode_q <= MODE_IDLE_FAST_ONLY;
            endcase
        end else if (halted_q && wakeUp) begin
            halted_q <= 1'b0;
            mode_q   <= (activeSrc_q == SRC_SLOW) ? MODE_SLOW : MODE_FAST;
        end else if (!halted_q) begin
            mode_q   <= (activeSrc_q == SRC_SLOW) ? MODE_SLOW : MODE_FAST;
        end
    end

    // registered oscillator status outputs
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fastOscOn_q <= 1'b0;
            slowOscOn_q <= 1'b0;
        end else begin
            fastOscOn_q <= fastRun;
            slowOscOn_q <= slowRun;
        end
    end

    // ==========================================================
    // AXI4-Lite write: address and data taken in either order
    assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
    assign s_axi_awready = !awHave_q && !s_axi_bvalid;
    assign s_axi_wready  = !wHave_q && !s_axi_bvalid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHave_q     <= 1'b0;
            wHave_q      <= 1'b0;
            awAddr_q     <= 4'h0;
            wData_q      <= 32'h0000_0000;
            wStrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHave_q     <= 1'b0;
                wHave_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awAddr_q == CLK_SEL_OFFSET || awAddr_q == OSC_CTRL_OFFSET)
                                ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register file; only byte lane 0 carries the 8-bit registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            srcField_q   <= SRC_RESET;
            keepFast_q   <= KEEP_RESET;
            keepSlow_q   <= KEEP_RESET;
            fastEnable_q <= ENABLE_RESET;
        end else if (doWrite && wStrb_q[0]) begin
            if (awAddr_q == CLK_SEL_OFFSET) begin
                srcField_q <= wData_q[SRC_MSB:SRC_LSB];
                keepFast_q <= wData_q[KEEP_FAST_BIT];
                keepSlow_q <= wData_q[KEEP_SLOW_BIT];
            end else if (awAddr_q == OSC_CTRL_OFFSET) begin
                fastEnable_q <= wData_q[ENABLE_BIT];
            end
        end
    end

    // ==========================================================
    // AXI4-Lite read, one outstanding
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (s_axi_araddr == CLK_SEL_OFFSET)
                s_axi_rdata <= {24'h000000, selReg};
            else if (s_axi_araddr == OSC_CTRL_OFFSET)
                s_axi_rdata <= {24'h000000, oscReg};
            else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    sequence fastStartS;
        !fastRunPrev_q && fastRun;
    endsequence

    rsvd_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_axi_rvalid |-> (s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[4:2] == 3'h0))
        else $error("reserved read bits not zero");
    flag_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        fastStartS |=> !stable_q)
        else $error("stable flag not cleared on start");
    flag_settle_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(stable_q) |-> $past(settle_q) == SW'(START_CYC - 1) && $past(fastRun))
        else $error("stable flag rose early");
    fast_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(activeSrc_q) && activeSrc_q != SRC_SLOW |-> stable_q)
        else $error("switched to unstable fast clock");
    halt_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!halted_q && haltPulse) |=> halted_q && mode_q ==
            ($past(keepFast_q) ? ($past(keepSlow_q) ? MODE_IDLE_BOTH_OSC : MODE_IDLE_FAST_ONLY)
                               : ($past(keepSlow_q) ? MODE_IDLE_SLOW_ONLY : MODE_SLEEP)))
        else $error("wrong low power mode");
    fast_halt_a: assert property (@(posedge clk) disable iff (!reset_n)
        halted_q && !keepFast_q |=> !fastOscOn_q)
        else $error("fast oscillator kept in halt");
    slow_halt_a: assert property (@(posedge clk) disable iff (!reset_n)
        halted_q && keepSlow_q |=> slowOscOn_q)
        else $error("slow oscillator stopped in halt");
    div_tick_a: assert property (@(posedge clk) disable iff (!reset_n)
        sysClkEn_q && $past(activeSrc_q) != SRC_SLOW |->
            (($past(fastCnt_q) | ~6'(((7'h01 << $past(activeSrc_q)) - 7'h01))) == 6'h3F))
        else $error("system tick off divider boundary");
    halt_noclk_a: assert property (@(posedge clk) disable iff (!reset_n)
        halted_q |=> !sysClkEn_q)
        else $error("system clock during halt");

endmodule : scs_clock_select

// ==== dv/tb_top.sv ====
/*
 * Self-checking bench for the system clock select block: register access over
 * AXI4-Lite, divider periods, halt modes and fast oscillator start-up.
 * Assumes scs_pkg is compiled first; start-up and slow tick counts are shortened.
 */
`timescale 1ns/1ps
module tb_top
    import scs_pkg::*;
;
    // ==========================================================
    // clock, reset and stimulus signals
    logic         clk;
    logic         reset_n;
    logic [3:0]   s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0]  s_axi_wdata, s_axi_rdata;
    logic         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic         s_axi_rvalid, s_axi_rready;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic         haltPulse, wakeUp, sysClkEn_q, fastOscOn_q, slowOscOn_q;
    scs_mode_type mode_q;
    int           n_mismatch, checked;

    // short counts keep the run brief; expectations use the same figures
    localparam int unsigned TB_START = 8;
    localparam int unsigned TB_SLOW  = 4;

    scs_clock_select #(.START_CYC(TB_START), .SLOW_DIV(TB_SLOW)) u_scs_clock_select (
        .clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .haltPulse(haltPulse), .wakeUp(wakeUp), .sysClkEn_q(sysClkEn_q),
        .fastOscOn_q(fastOscOn_q), .slowOscOn_q(slowOscOn_q), .mode_q(mode_q));

    // 50 MHz clock
    always #10 clk = ~clk;

    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask : check

    // ready is sampled at the falling edge, so the handshake edge is the next rising one
    task automatic axi_write(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
        logic awPend, wPend, awHit, wHit;
        awPend = 1'b1;
        wPend = 1'b1;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (awPend || wPend) begin
            @(negedge clk);
            awHit = awPend && (s_axi_awready === 1'b1);
            wHit = wPend && (s_axi_wready === 1'b1);
            @(posedge clk);
            if (awHit) s_axi_awvalid <= 1'b0;
            if (wHit) s_axi_wvalid <= 1'b0;
            awPend = awPend && !awHit;
            wPend = wPend && !wHit;
        end
        @(negedge clk);
        while (s_axi_bvalid !== 1'b1) @(negedge clk);
        r = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(negedge clk);
        while (s_axi_arready !== 1'b1) @(negedge clk);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        @(negedge clk);
        while (s_axi_rvalid !== 1'b1) @(negedge clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic read_check(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0]  r;
        axi_read(a, v, r);
        check(v, exp);
    endtask : read_check

    // software polls the flag before trusting the fast source
    task automatic wait_stable;
        logic [31:0] v;
        logic [1:0]  r;
        v = '0;
        for (int n = 0; n < 40 && v[STABLE_BIT] !== 1'b1; n++) axi_read(OSC_CTRL_OFFSET, v, r);
    endtask : wait_stable

    // skips the switch-over boundary, then counts cycles between enables
    task automatic measure(output int p);
        repeat (3) begin
            @(negedge clk);
            for (int n = 0; n < 300 && sysClkEn_q !== 1'b1; n++) @(negedge clk);
        end
        p = 0;
        do begin
            @(negedge clk);
            p++;
        end while (sysClkEn_q !== 1'b1 && p < 300);
    endtask : measure

    // ==========================================================
    // scenarios
    task automatic test_regs;
        logic [1:0]  r;
        logic [31:0] v;
        read_check(CLK_SEL_OFFSET, 32'h00000000);
        read_check(OSC_CTRL_OFFSET, 32'h00000001);
        check(32'(mode_q), 32'(MODE_FAST));
        wait_stable();
        read_check(OSC_CTRL_OFFSET, 32'h00000003);
        axi_write(OSC_CTRL_OFFSET, 8'hFC, r);
        read_check(OSC_CTRL_OFFSET, 32'h00000000);
        axi_write(OSC_CTRL_OFFSET, 8'hFF, r);
        read_check(OSC_CTRL_OFFSET, 32'h00000001);
        wait_stable();
        read_check(OSC_CTRL_OFFSET, 32'h00000003);
        axi_write(CLK_SEL_OFFSET, 8'hFF, r);
        read_check(CLK_SEL_OFFSET, 32'h000000E3);
        axi_write(CLK_SEL_OFFSET, 8'h00, r);
        // lane 0 masked off: the write is answered but changes nothing
        s_axi_wstrb <= 4'hE;
        axi_write(CLK_SEL_OFFSET, 8'hFF, r);
        s_axi_wstrb <= 4'hF;
        check(32'(r), 32'(RESP_OKAY));
        read_check(CLK_SEL_OFFSET, 32'h00000000);
        axi_write(4'h8, 8'hFF, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_read(4'h8, v, r);
        check(v, 32'h00000000);
        check(32'(r), 32'(RESP_SLVERR));
        $display("done: register access");
    endtask : test_regs

    task automatic test_divider;
        logic [1:0] r;
        int         p;
        for (int s = 0; s < 8; s++) begin
            axi_write(CLK_SEL_OFFSET, {s[2:0], 5'h00}, r);
            measure(p);
            check(32'(p), (s == 7) ? 32'(TB_SLOW) : (32'h1 << s));
            check(32'(mode_q), (s == 7) ? 32'(MODE_SLOW) : 32'(MODE_FAST));
        end
        $display("done: clock source divider");
    endtask : test_divider

    // still on the slow source here; fast is switched off under it
    task automatic test_enable;
        logic [1:0] r;
        int         p;
        axi_write(OSC_CTRL_OFFSET, 8'h00, r);
        repeat (4) @(posedge clk);
        read_check(OSC_CTRL_OFFSET, 32'h00000000);
        check(32'(fastOscOn_q), 32'h0);
        axi_write(CLK_SEL_OFFSET, 8'h00, r);
        repeat (20) @(posedge clk);
        check(32'(mode_q), 32'(MODE_SLOW));
        axi_write(OSC_CTRL_OFFSET, 8'h01, r);
        read_check(OSC_CTRL_OFFSET, 32'h00000001);
        wait_stable();
        read_check(OSC_CTRL_OFFSET, 32'h00000003);
        measure(p);
        check(32'(p), 32'h1);
        check(32'(mode_q), 32'(MODE_FAST));
        $display("done: fast oscillator enable");
    endtask : test_enable

    task automatic test_halt;
        logic [1:0]   r;
        scs_mode_type modes [4];
        modes = '{MODE_SLEEP, MODE_IDLE_SLOW_ONLY, MODE_IDLE_FAST_ONLY, MODE_IDLE_BOTH_OSC};
        for (int i = 0; i < 4; i++) begin
            axi_write(CLK_SEL_OFFSET, {6'h00, i[1:0]}, r);
            @(posedge clk);
            haltPulse <= 1'b1;
            @(posedge clk);
            haltPulse <= 1'b0;
            repeat (3) @(negedge clk);
            check(32'(mode_q), 32'(modes[i]));
            check(32'(fastOscOn_q), 32'(i[1]));
            check(32'(slowOscOn_q), 32'(i[0]));
            check(32'(sysClkEn_q), 32'h0);
            @(posedge clk);
            wakeUp <= 1'b1;
            @(posedge clk);
            wakeUp <= 1'b0;
            wait_stable();
            read_check(OSC_CTRL_OFFSET, 32'h00000003);
            check(32'(mode_q), 32'(MODE_FAST));
        end
        $display("done: halt modes");
    endtask : test_halt

    // ==========================================================
    // verdict, main sequence and watchdog
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        haltPulse = 1'b0;
        wakeUp = 1'b0;
        n_mismatch = 0;
        checked = 0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        test_regs();
        test_divider();
        test_enable();
        test_halt();
        give_verdict();
    end

    // whole run needs about a thousand cycles; this cuts off a hang
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule : tb_top
